// [src/ulp_consts.svh]
// Purpose: Named constants for the ULPI transceiver control block
// Assumes: Included by the design module and the testbench
// Notes:   Register offsets are byte addresses on the plain register port
`ifndef ULP_CONSTS_SVH
`define ULP_CONSTS_SVH
// Register byte offsets and control reset value
`define ULP_R_CTRL    4'h0
`define ULP_R_INTEN   4'h4
`define ULP_R_STAT    4'h8
`define ULP_R_LATCH   4'hC
`define ULP_CTRL_RST  10'h000
// Control field positions
`define ULP_C_IDEN    0
`define ULP_C_DIS     1
`define ULP_C_CHG     2
`define ULP_C_SER     3
`define ULP_C_HIZ     5
`define ULP_C_PD      6
`define ULP_C_LP      7
`define ULP_C_SPD     8
// Serial mode codes and pin output enables
`define ULP_SER_PAR   2'h0
`define ULP_SER_6     2'h1
`define ULP_SER_3     2'h2
`define ULP_SER6_OE   8'h30
`define ULP_SER3_OE   8'h06
// Event latch positions
`define ULP_L_ID      0
`define ULP_L_SESS    1
`define ULP_L_STUFF   2
`define ULP_L_OVR     3
`define ULP_L_UDR     4
`define ULP_L_ALIGN   5
// ULPI command classes
`define ULP_CMD_TX    2'h1
`define ULP_CMD_RW    2'h2
`define ULP_CMD_RR    2'h3
// Line coding
`define ULP_SYNC      8'h80
`define ULP_STUFF_MAX 3'h6
`define ULP_BYTE_BITS 4'h8
`define ULP_EOP_SE0   2'h2
`define ULP_EOP_LEN   2'h3
// Status update fields
`define ULP_EV_ACT    2'h1
`define ULP_EV_ERR    2'h3
`define ULP_VB_END    2'h0
`define ULP_VB_LOW    2'h1
`define ULP_VB_SESS   2'h2
`define ULP_VB_VALID  2'h3
// Synchroniser lanes
`define ULP_I_BCLK    0
`define ULP_I_RXV     1
`define ULP_I_DP      2
`define ULP_I_SE0     3
`define ULP_I_ID      4
`define ULP_I_SEND    5
`define ULP_I_SVLD    6
`define ULP_I_VVLD    7
`endif

// [src/ulp_pkg.sv]
// Purpose: Types for the ULPI transceiver control block
// Assumes: ulp_consts.svh holds all numbers except the state encodings
// Notes:   Whole module state is one packed struct
package ulp_pkg;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_TX   = 6'h02,
        ST_REGW = 6'h04,
        ST_REGR = 6'h08,
        ST_CMD  = 6'h10,
        ST_RX   = 6'h20
    } ulp_state_t;

    typedef struct packed {
        ulp_state_t  st;
        logic [1:0]  ph;
        logic [7:0]  sy1;
        logic [7:0]  sy2;
        logic        bclk_prev;
        logic        rxv_prev;
        logic [9:0]  ctrl;
        logic [1:0]  inten;
        logic [5:0]  latch;
        logic [31:0] rdata;
        logic        rid;
        logic        rsess;
        logic        cmd_pend;
        logic [1:0]  radr;
        logic [7:0]  dout;
        logic [7:0]  doe;
        logic        dir;
        logic        dir_oe;
        logic        nxt;
        logic [7:0]  tx_sh;
        logic [3:0]  tx_cnt;
        logic [2:0]  tx_ones;
        logic [7:0]  tx_hold;
        logic        tx_hv;
        logic        tx_last;
        logic        tx_pid;
        logic [1:0]  tx_eop;
        logic        tx_act;
        logic        tx_en;
        logic        tx_dp;
        logic        tx_se0;
        logic [7:0]  rx_sh;
        logic [3:0]  rx_cnt;
        logic [2:0]  rx_ones;
        logic        rx_prev;
        logic        rx_sync;
        logic [7:0]  rx_byte;
        logic        rx_bv;
        logic        rx_act;
        logic        rx_errf;
    } ulp_regs_t;
endpackage

// [src/ulp_phy_ctrl.sv]
// Purpose: ULPI interface controller, USB serializer/deserializer and OTG control
// Assumes: ULPI bus runs on sys_clk; USB line side and analog inputs are asynchronous
`timescale 1ns/1ps
`include "ulp_consts.svh"

module ulp_phy_ctrl (
    // System
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_we,
    input  wire logic        reg_re,
    output wire logic [31:0] reg_rdata,
    // ULPI bus
    input  wire logic [7:0]  ulpi_din,
    output wire logic [7:0]  ulpi_dout,
    output wire logic [7:0]  ulpi_doe,
    input  wire logic        ulpi_stp,
    output wire logic        ulpi_dir,
    output wire logic        ulpi_dir_oe,
    output wire logic        ulpi_nxt,
    output wire logic        ulpi_pd_en,
    // USB line side
    input  wire logic        usb_bit_clk,
    input  wire logic        usb_rx_valid,
    input  wire logic        usb_rx_dp,
    input  wire logic        usb_rx_se0,
    output wire logic        usb_tx_en,
    output wire logic        usb_tx_dp,
    output wire logic        usb_tx_se0,
    output wire logic [1:0]  usb_speed,
    // OTG analog
    input  wire logic        id_pin,
    input  wire logic        session_end_flag_in,
    input  wire logic        sess_valid_in,
    input  wire logic        vbus_valid_in,
    output wire logic        id_pull_en,
    output wire logic        vbus_dischg_en,
    output wire logic        vbus_chg_en
);
    ulp_pkg::ulp_regs_t q;
    ulp_pkg::ulp_regs_t d;

    // Register view shared by software and ULPI reads
    function automatic logic [31:0] reg_view(input logic [3:0] a);
        reg_view = 32'h0;
        case (a)
            `ULP_R_CTRL:  reg_view = {22'h0, q.ctrl};
            `ULP_R_INTEN: reg_view = {30'h0, q.inten};
            `ULP_R_STAT:  reg_view = {26'h0, q.tx_act, q.rx_act, q.sy2[`ULP_I_VVLD],
                                      q.sy2[`ULP_I_SVLD], q.rsess, q.rid};
            `ULP_R_LATCH: reg_view = {26'h0, q.latch};
            default:      reg_view = 32'h0;
        endcase
    endfunction

    logic       bedge;
    logic       id_now;
    logic [1:0] vb;
    logic [1:0] ev;
    logic [1:0] ls;
    logic [7:0] rxcmd;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic       rd;
    logic [1:0] ser;

    always_comb
    begin
        d = q;
        bedge = 1'b0;
        id_now = 1'b0;
        vb = `ULP_VB_END;
        ev = 2'h0;
        ls = 2'h0;
        rxcmd = 8'h00;
        sh = 8'h00;
        cnt = 4'h0;
        rd = 1'b0;
        ser = q.ctrl[`ULP_C_SER +: 2];
        d.sy1 = {vbus_valid_in, sess_valid_in, session_end_flag_in, id_pin,
                 usb_rx_se0, usb_rx_dp, usb_rx_valid, usb_bit_clk};
        d.sy2 = q.sy1;
        d.bclk_prev = q.sy2[`ULP_I_BCLK];
        d.rxv_prev = q.sy2[`ULP_I_RXV];
        bedge = q.sy2[`ULP_I_BCLK] & ~q.bclk_prev;
        d.rdata = 32'h0;
        d.nxt = 1'b0;

        // Software register port
        if (reg_we)
        begin
            case (reg_addr)
                `ULP_R_CTRL:  d.ctrl = reg_wdata[9:0];
                `ULP_R_INTEN: d.inten = reg_wdata[1:0];
                `ULP_R_LATCH: d.latch = q.latch & ~reg_wdata[5:0];
                default:      d.ctrl = q.ctrl;
            endcase
        end
        if (reg_re)
            d.rdata = reg_view(reg_addr);

        // Status update byte
        vb = q.rsess ? `ULP_VB_END : q.sy2[`ULP_I_VVLD] ? `ULP_VB_VALID :
             q.sy2[`ULP_I_SVLD] ? `ULP_VB_SESS : `ULP_VB_LOW;
        ev = q.rx_errf ? `ULP_EV_ERR : q.rx_act ? `ULP_EV_ACT : 2'h0;
        ls = q.sy2[`ULP_I_SE0] ? 2'h0 : {~q.sy2[`ULP_I_DP], q.sy2[`ULP_I_DP]};
        rxcmd = {1'b0, q.rid, ev, vb, ls};

        // ULPI bus arbitration and transfers
        case (q.st)
            ulp_pkg::ST_IDLE:
            begin
                d.doe = 8'h00;
                d.dir = q.ctrl[`ULP_C_LP];
                d.ph = 2'h0;
                if (ser == `ULP_SER_6)
                    d.doe = `ULP_SER6_OE;
                else if (ser == `ULP_SER_3)
                    d.doe = ulpi_din[0] ? 8'h00 : `ULP_SER3_OE;
                if (ser != `ULP_SER_PAR)
                    d.dout = {2'h0, q.sy2[`ULP_I_SE0], q.sy2[`ULP_I_DP], 1'b0,
                              q.sy2[`ULP_I_SE0], q.sy2[`ULP_I_DP], 1'b0};
                else if (q.ctrl[`ULP_C_LP])
                    d.dir = 1'b1;
                else if (q.rx_act || q.rx_bv)
                begin
                    d.st = ulp_pkg::ST_RX;
                    d.dir = 1'b1;
                end
                else if (q.cmd_pend)
                begin
                    d.st = ulp_pkg::ST_CMD;
                    d.dir = 1'b1;
                    d.cmd_pend = 1'b0;
                end
                else if (ulpi_din[7:6] == `ULP_CMD_TX && !q.tx_act)
                begin
                    d.st = ulp_pkg::ST_TX;
                    d.nxt = 1'b1;
                    d.tx_act = 1'b1;
                    d.tx_last = 1'b0;
                    d.tx_eop = 2'h0;
                    d.tx_ones = 3'h0;
                    d.tx_dp = 1'b1;
                    d.tx_pid = ulpi_din[3:0] != 4'h0;
                    d.tx_sh = `ULP_SYNC;
                    d.tx_cnt = d.tx_pid ? `ULP_BYTE_BITS : 4'h0;
                    d.tx_hold = {~ulpi_din[3:0], ulpi_din[3:0]};
                    d.tx_hv = d.tx_pid;
                end
                else if (ulpi_din[7:6] == `ULP_CMD_RW || ulpi_din[7:6] == `ULP_CMD_RR)
                begin
                    d.st = ulpi_din[6] ? ulp_pkg::ST_REGR : ulp_pkg::ST_REGW;
                    d.nxt = 1'b1;
                    d.radr = ulpi_din[1:0];
                end
            end
            ulp_pkg::ST_TX:
            begin
                d.ph = 2'h1;
                if (ulpi_stp)
                begin
                    d.tx_last = 1'b1;
                    d.st = ulp_pkg::ST_IDLE;
                end
                else if (q.nxt && q.ph != 2'h0)
                begin
                    d.tx_hold = ulpi_din;
                    d.tx_hv = 1'b1;
                end
            end
            ulp_pkg::ST_REGW:
            begin
                d.ph = (q.ph == 2'h2) ? q.ph : q.ph + 2'h1;
                d.nxt = q.ph == 2'h0;
                if (q.ph == 2'h1)
                begin
                    case ({q.radr, 2'h0})
                        `ULP_R_CTRL:  d.ctrl[7:0] = ulpi_din;
                        `ULP_R_INTEN: d.inten = ulpi_din[1:0];
                        `ULP_R_LATCH: d.latch = q.latch & ~ulpi_din[5:0];
                        default:      d.ctrl = q.ctrl;
                    endcase
                end
                if (ulpi_stp)
                    d.st = ulp_pkg::ST_IDLE;
            end
            ulp_pkg::ST_REGR, ulp_pkg::ST_CMD:
            begin
                d.dir = 1'b1;
                d.ph = q.ph + 2'h1;
                if (q.ph == 2'h1)
                begin
                    d.doe = 8'hFF;
                    d.dout = (q.st == ulp_pkg::ST_CMD) ? rxcmd : 8'(reg_view({q.radr, 2'h0}));
                end
                else if (q.ph == 2'h2)
                begin
                    d.dir = 1'b0;
                    d.doe = 8'h00;
                    d.st = ulp_pkg::ST_IDLE;
                end
            end
            ulp_pkg::ST_RX:
            begin
                d.ph = 2'h1;
                if (q.ph != 2'h0)
                begin
                    d.doe = 8'hFF;
                    if (q.rx_bv)
                    begin
                        d.dout = q.rx_byte;
                        d.nxt = 1'b1;
                        d.rx_bv = 1'b0;
                    end
                    else
                    begin
                        d.dout = rxcmd;
                        if (!q.rx_act)
                        begin
                            d.dir = 1'b0;
                            d.doe = 8'h00;
                            d.st = ulp_pkg::ST_IDLE;
                        end
                    end
                end
            end
            default:
                d.st = ulp_pkg::ST_IDLE;
        endcase

        // Abort by STP while the device owns the bus
        if (q.dir && ulpi_stp && (q.st == ulp_pkg::ST_RX || q.st == ulp_pkg::ST_CMD ||
                                  q.st == ulp_pkg::ST_REGR))
        begin
            d.dir = 1'b0;
            d.doe = 8'h00;
            d.nxt = 1'b0;
            d.rx_bv = 1'b0;
            d.st = ulp_pkg::ST_IDLE;
        end

        // OTG change detection, set wins over clear
        id_now = q.ctrl[`ULP_C_IDEN] & q.sy2[`ULP_I_ID];
        if (id_now != q.rid)
        begin
            d.rid = id_now;
            d.latch[`ULP_L_ID] = 1'b1;
            if (q.inten[0])
                d.cmd_pend = 1'b1;
        end
        if (q.sy2[`ULP_I_SEND] != q.rsess)
        begin
            d.rsess = q.sy2[`ULP_I_SEND];
            d.latch[`ULP_L_SESS] = 1'b1;
            if (q.inten[1])
                d.cmd_pend = 1'b1;
        end

        // Transmit serializer
        if (ser != `ULP_SER_PAR)
        begin
            d.tx_en = ulpi_din[0];
            d.tx_dp = ulpi_din[1];
            d.tx_se0 = ulpi_din[2];
        end
        else if (bedge && q.tx_act)
        begin
            sh = q.tx_sh;
            cnt = q.tx_cnt;
            if (cnt == 4'h0 && q.tx_hv)
            begin
                sh = q.tx_hold;
                cnt = `ULP_BYTE_BITS;
                d.tx_hv = 1'b0;
            end
            d.tx_en = 1'b1;
            if (q.tx_ones == `ULP_STUFF_MAX)
            begin
                d.tx_dp = ~q.tx_dp;
                d.tx_ones = 3'h0;
                d.tx_sh = sh;
                d.tx_cnt = cnt;
            end
            else if (cnt != 4'h0)
            begin
                d.tx_sh = {1'b0, sh[7:1]};
                d.tx_cnt = cnt - 4'h1;
                d.tx_dp = sh[0] ? q.tx_dp : ~q.tx_dp;
                d.tx_ones = sh[0] ? q.tx_ones + 3'h1 : 3'h0;
            end
            else if (q.tx_last && q.tx_pid && q.tx_eop != `ULP_EOP_LEN)
            begin
                d.tx_se0 = q.tx_eop < `ULP_EOP_SE0;
                d.tx_dp = 1'b1;
                d.tx_eop = q.tx_eop + 2'h1;
            end
            else if (q.tx_last)
            begin
                d.tx_act = 1'b0;
                d.tx_en = 1'b0;
                d.tx_se0 = 1'b0;
            end
        end
        if (d.st == ulp_pkg::ST_TX && q.st == ulp_pkg::ST_TX)
            d.nxt = !d.tx_hv && !ulpi_stp;

        // Receive deserializer
        if (q.sy2[`ULP_I_RXV] && !q.rxv_prev && ser == `ULP_SER_PAR)
        begin
            d.rx_act = 1'b1;
            d.rx_sync = 1'b0;
            d.rx_cnt = 4'h0;
            d.rx_ones = 3'h0;
            d.rx_prev = 1'b1;
            d.rx_errf = 1'b0;
        end
        else if (q.rx_act && !q.sy2[`ULP_I_RXV])
        begin
            d.rx_act = 1'b0;
            d.latch[`ULP_L_UDR] = 1'b1;
        end
        else if (q.rx_act && bedge && q.sy2[`ULP_I_SE0])
        begin
            d.rx_act = 1'b0;
            if (q.rx_cnt != 4'h0)
            begin
                d.latch[`ULP_L_ALIGN] = 1'b1;
                d.rx_errf = 1'b1;
            end
        end
        else if (q.rx_act && bedge)
        begin
            rd = q.sy2[`ULP_I_DP] == q.rx_prev;
            d.rx_prev = q.sy2[`ULP_I_DP];
            if (!q.rx_sync)
            begin
                d.rx_sync = rd;
                d.rx_ones = rd ? 3'h1 : 3'h0;
            end
            else if (q.rx_ones == `ULP_STUFF_MAX)
            begin
                d.rx_ones = 3'h0;
                if (rd)
                begin
                    d.latch[`ULP_L_STUFF] = 1'b1;
                    d.rx_errf = 1'b1;
                end
            end
            else
            begin
                d.rx_sh = {rd, q.rx_sh[7:1]};
                d.rx_ones = rd ? q.rx_ones + 3'h1 : 3'h0;
                d.rx_cnt = q.rx_cnt + 4'h1;
                if (q.rx_cnt == `ULP_BYTE_BITS - 4'h1)
                begin
                    d.rx_cnt = 4'h0;
                    d.rx_byte = {rd, q.rx_sh[7:1]};
                    if (d.rx_bv)
                        d.latch[`ULP_L_OVR] = 1'b1;
                    d.rx_bv = 1'b1;
                end
            end
        end

        // Bus state control
        d.dir_oe = ~q.ctrl[`ULP_C_HIZ];
        if (q.ctrl[`ULP_C_HIZ])
            d.doe = 8'h00;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            q <= '0;
            q.st <= ulp_pkg::ST_IDLE;
            q.ctrl <= `ULP_CTRL_RST;
            q.dir <= 1'b1;
            q.tx_dp <= 1'b1;
        end
        else
            q <= d;
    end

    assign reg_rdata = q.rdata;
    assign ulpi_dout = q.dout;
    assign ulpi_doe = q.doe;
    assign ulpi_dir = q.dir;
    assign ulpi_dir_oe = q.dir_oe;
    assign ulpi_nxt = q.nxt;
    assign ulpi_pd_en = q.ctrl[`ULP_C_PD];
    assign usb_tx_en = q.tx_en;
    assign usb_tx_dp = q.tx_dp;
    assign usb_tx_se0 = q.tx_se0;
    assign usb_speed = q.ctrl[`ULP_C_SPD +: 2];
    assign id_pull_en = q.ctrl[`ULP_C_IDEN];
    assign vbus_dischg_en = q.ctrl[`ULP_C_DIS];
    assign vbus_chg_en = q.ctrl[`ULP_C_CHG];

    chk_dir_reset: assert property (@(posedge sys_clk) $rose(rstn) |-> q.dir)
        else $error("DIR not high on reset release");
    chk_stp_abort: assert property (@(posedge sys_clk) disable iff (!rstn)
        (q.dir && ulpi_stp && q.st == ulp_pkg::ST_RX) |=> !q.dir)
        else $error("DIR not dropped after STP");
    chk_nxt_busy: assert property (@(posedge sys_clk) disable iff (!rstn)
        (q.st == ulp_pkg::ST_TX && q.ph != 2'h0 && q.tx_hv) |-> !q.nxt)
        else $error("NXT high while serializer full");
    chk_rx_nxt_dir: assert property (@(posedge sys_clk) disable iff (!rstn)
        (q.nxt && q.dir) |-> $past(q.dir) && q.doe == 8'hFF)
        else $error("Receive byte without prior DIR");
    chk_tx_stuff: assert property (@(posedge sys_clk) disable iff (!rstn)
        (q.tx_act && q.tx_ones == `ULP_STUFF_MAX && bedge) |=> q.tx_ones == 3'h0 && $changed(q.tx_dp))
        else $error("Stuff bit missing");
    chk_cmd_idbit: assert property (@(posedge sys_clk) disable iff (!rstn)
        (q.st == ulp_pkg::ST_CMD && q.ph == 2'h2) |-> q.dout[6] == $past(q.rid))
        else $error("Status byte ID field wrong");
    chk_id_update: assert property (@(posedge sys_clk) disable iff (!rstn)
        (id_now != q.rid && q.inten[0]) |=> q.cmd_pend || q.st == ulp_pkg::ST_CMD)
        else $error("ID change not reported");
    chk_serial_oe: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ser == `ULP_SER_6 && q.st == ulp_pkg::ST_IDLE && !q.ctrl[`ULP_C_HIZ]) |=> q.doe == `ULP_SER6_OE)
        else $error("Six-pin output enables wrong");
    chk_hiz_float: assert property (@(posedge sys_clk) disable iff (!rstn)
        q.ctrl[`ULP_C_HIZ] |=> !q.dir_oe && q.doe == 8'h00)
        else $error("Pins driven while floated");
endmodule

// [bench/ulp_link_model.sv]
// Purpose: Link side of ULPI, sends one command and one data byte
// Assumes: Link drives the data lines while DIR is low
// Notes:   Idle data lines held at zero
`timescale 1ns/1ps
module ulp_link_model (
    // Control
    input  wire logic       sys_clk,
    input  wire logic       go,
    input  wire logic [7:0] cmd,
    input  wire logic [7:0] dat,
    // ULPI
    input  wire logic       nxt,
    input  wire logic       dir,
    output logic      [7:0] din = 8'h00,
    output logic            stp = 1'b0
);
    logic [1:0] ph = 2'h0;
    always @(posedge sys_clk)
    begin
        case (ph)
            2'h0: if (go)
            begin
                din <= cmd;
                ph  <= 2'h1;
            end
            2'h1: if (nxt && !dir)
            begin
                din <= dat;
                ph  <= 2'h2;
            end
            2'h2: if (nxt && !dir)
            begin
                din <= 8'h00;
                stp <= 1'b1;
                ph  <= 2'h3;
            end
            default:
            begin
                stp <= 1'b0;
                ph  <= 2'h0;
            end
        endcase
    end
endmodule

// [bench/ulpi_phy_datapath_otg_control_test.sv]
// Purpose: Self-checking bench for the ULPI control block
// Assumes: Link model drives the ULPI inputs
// Notes:   Receive line inputs driven bit by bit in the receive scenario
`timescale 1ns/1ps
`include "ulp_consts.svh"
module ulpi_phy_datapath_otg_control_test;
    logic sys_clk = 0, rstn = 0, we = 0, re = 0, go = 0, bclk = 0, idp = 0, se = 0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0, rd, v;
    logic [7:0] dout, doe, din;
    logic dir, nxt, stp, txe, txdp, txse0, ide, dis, chg;
    logic rdp = 1, rxv = 0, rse = 0, sv = 0, vv = 0, pde, dioe;
    logic [1:0] spd;
    logic [7:0] lcmd = 8'h00, ldat = 8'h00, rxb = 8'h00;
    int fails = 0, n_compared = 0, cyc = 0, k, np, nrx = 0;
    initial forever #20 sys_clk = ~sys_clk;
    initial forever #160 bclk = ~bclk;
    ulp_link_model ulp_link_model_i (.sys_clk(sys_clk), .go(go), .cmd(lcmd), .dat(ldat),
        .nxt(nxt), .dir(dir), .din(din), .stp(stp));
    ulp_phy_ctrl ulp_phy_ctrl_i (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(adr), .reg_wdata(wd),
        .reg_we(we), .reg_re(re), .reg_rdata(rd), .ulpi_din(din), .ulpi_dout(dout), .ulpi_doe(doe),
        .ulpi_stp(stp), .ulpi_dir(dir), .ulpi_dir_oe(dioe), .ulpi_nxt(nxt), .ulpi_pd_en(pde),
        .usb_bit_clk(bclk), .usb_rx_valid(rxv), .usb_rx_dp(rdp), .usb_rx_se0(rse), .usb_tx_en(txe),
        .usb_tx_dp(txdp), .usb_tx_se0(txse0), .usb_speed(spd), .id_pin(idp), .session_end_flag_in(se),
        .sess_valid_in(sv), .vbus_valid_in(vv), .id_pull_en(ide), .vbus_dischg_en(dis),
        .vbus_chg_en(chg));
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge sys_clk) {we, adr, wd} <= {1'b1, a, d};
        @(posedge sys_clk) we <= 0;
    endtask
    task automatic rdr(logic [3:0] a);
        @(posedge sys_clk) {re, adr} <= {1'b1, a};
        @(posedge sys_clk) re <= 0;
        #1 v = rd;
    endtask
    task automatic lnk(logic [7:0] c, logic [7:0] d);
        @(posedge sys_clk) {go, lcmd, ldat} <= {1'b1, c, d};
        @(posedge sys_clk) go <= 0;
    endtask
    task automatic complete_run;
        if (fails == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_otg;
        chk("dir_reset", 1, dir);
        rstn <= 1;
        lnk(8'h80, 8'h40);
        repeat (8) @(posedge sys_clk);
        rdr(`ULP_R_CTRL);
        chk("ulpi_write", 32'h40, v);
        chk("pull_down", 1, pde);
        wr(`ULP_R_INTEN, 32'h1);
        @(posedge sys_clk) idp <= 1;
        wr(`ULP_R_CTRL, 32'h1);
        for (k = 0; k < 60 && !(doe === 8'hFF && nxt === 0); k++) @(negedge sys_clk);
        chk("rxcmd_id", 1, dout[6]);
        rdr(`ULP_R_STAT);
        chk("id_grounded_b", 1, v[0]);
        @(posedge sys_clk) idp <= 0;
        repeat (8) @(posedge sys_clk);
        rdr(`ULP_R_STAT);
        chk("id_grounded_a", 0, v[0]);
        wr(`ULP_R_CTRL, 32'h3);
        se <= 1;
        repeat (6) @(posedge sys_clk);
        rdr(`ULP_R_STAT);
        chk("session_end", 1, v[1]);
        @(posedge sys_clk) {sv, vv} <= 2'b11;
        repeat (4) @(posedge sys_clk);
        rdr(`ULP_R_STAT);
        chk("bus_valid", 2'b11, v[3:2]);
        wr(`ULP_R_CTRL, 32'h5);
        #1 chk("ctrl_pins", 3'b101, {chg, dis, ide});
        rdr(4'h2);
        chk("unmapped", 0, v);
        wr(`ULP_R_CTRL, 32'h220);
        @(posedge sys_clk);
        #1 chk("float_dir_oe", 0, dioe);
        chk("speed_sel", 2, spd);
        wr(`ULP_R_CTRL, 32'h8);
        repeat (3) @(posedge sys_clk);
        #1 chk("six_pin_oe", 8'h30, doe);
        chk("six_pin_line", 2'b01, dout[5:4]);
        wr(`ULP_R_CTRL, 32'h80);
        repeat (3) @(posedge sys_clk);
        chk("dir_lowpower", 1, dir);
        wr(`ULP_R_CTRL, 32'h0);
        repeat (60) @(posedge sys_clk);
    endtask
    task automatic t_tx;
        np = 0;
        lnk(8'h43, 8'hA5);
        for (k = 0; k < 300 && txe !== 1; k++) @(negedge sys_clk) np += (nxt === 1);
        chk("tx_start", 1, txe);
        v = 0;
        for (k = 0; k < 900 && txe !== 0; k++) @(negedge sys_clk)
        begin
            np += (nxt === 1);
            v[0] |= (txse0 === 1);
        end
        chk("tx_end", 0, txe);
        chk("eop_seen", 1, v[0]);
        chk("nxt_count", 2, np);
    endtask
    task automatic t_rx(int nb);
        logic [16:0] w;
        w = {1'b0, 8'h5A, 8'h80};
        np = nrx;
        for (k = 0; k < nb; k++)
        begin
            @(negedge bclk);
            @(posedge sys_clk) {rxv, rdp} <= {1'b1, rdp ^ !w[k]};
        end
        @(negedge bclk);
        @(posedge sys_clk) rse <= 1;
        @(negedge bclk);
        @(posedge sys_clk) {rxv, rse, rdp} <= 3'b001;
        repeat (12) @(posedge sys_clk);
        rdr(`ULP_R_LATCH);
        chk("rx_byte", 8'h5A, rxb);
        chk("rx_count", np + 1, nrx);
        chk("rx_flags", {nb != 16, 3'b000}, v[5:2]);
        chk("rx_release", 0, dir);
    endtask
    always @(negedge sys_clk)
    begin
        if (nxt === 1 && dir === 1)
        begin
            rxb <= dout;
            nrx <= nrx + 1;
        end
    end
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            complete_run();
        end
    end
    initial
    begin
        repeat (6) @(posedge sys_clk);
        t_otg();
        t_tx();
        t_rx(16);
        t_rx(17);
        complete_run();
    end
endmodule
